// file: hw/dprs_defines.vh
`ifndef DPRS_DEFINES_VH
`define DPRS_DEFINES_VH

// debug register select codes
`define DPRS_SEL_PART      8'h00
`define DPRS_SEL_REVISION  8'h01
`define DPRS_SEL_PROG_CTRL 8'h02
`define DPRS_SEL_PROG_DATA 8'hB4
`define DPRS_SEL_RESET     8'h00

// link instruction codes, two bits, first bit is bit 0
`define DPRS_INS_DATA_READ  2'h0
`define DPRS_INS_DATA_WRITE 2'h1
`define DPRS_INS_ADDR_READ  2'h2
`define DPRS_INS_ADDR_WRITE 2'h3

// programming control unlock codes
`define DPRS_UNLOCK_FIRST  8'h02
`define DPRS_UNLOCK_SECOND 8'h01

// programming data command codes
`define DPRS_CMD_BLOCK_READ  8'h06
`define DPRS_CMD_BLOCK_WRITE 8'h07
`define DPRS_CMD_PAGE_ERASE  8'h08
`define DPRS_CMD_DEVICE_ERASE 8'h03

// frame field last-bit indices (one less than field length), zero byte
`define DPRS_INS_LAST  3'h1
`define DPRS_DATA_LAST 3'h7
`define DPRS_BYTE_ZERO 8'h00

`endif

// file: hw/dprs_debug_port.v
`timescale 1ns/1ps
`default_nettype none
`include "dprs_defines.vh"

module dprs_debug_port #(
    parameter [7:0] PART_ID = 8'h5A, // arbitrary value
    parameter [7:0] REV_ID = 8'h00   // arbitrary value
) (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // two-wire debug link
    input wire debugClockPin,
    input wire debugDataPinIn,
    output wire debugDataPinOut,
    output wire debugDataPinOe,
    // flash programming side
    input wire progDataLoad,
    input wire [7:0] progDataIn,
    output reg progEnabled_q,
    output reg progDataWrite_q,
    output reg progCmdMatch_q,
    output reg [7:0] progData_q,
    output reg [7:0] debugRegisterSelect_q
);

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_INS = 2'h1;
    localparam [1:0] ST_DIN = 2'h2;
    localparam [1:0] ST_DOUT = 2'h3;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg clkMeta_q;
    reg clkSync_q;
    reg clkPrev_q;
    reg datMeta_q;
    reg datSync_q;

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            clkMeta_q <= 1'b0;
            clkSync_q <= 1'b0;
            clkPrev_q <= 1'b0;
            datMeta_q <= 1'b1;
            datSync_q <= 1'b1;
        end
        else
        begin
            clkMeta_q <= debugClockPin;
            clkSync_q <= clkMeta_q;
            clkPrev_q <= clkSync_q;
            datMeta_q <= debugDataPinIn;
            datSync_q <= datMeta_q;
        end
    end

    wire linkRise = clkSync_q & ~clkPrev_q;
    wire linkFall = ~clkSync_q & clkPrev_q;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    reg [7:0] progCtrl_q;
    reg [7:0] readValue;

    // unlisted selects answer zero rather than floating the line
    always @*
    begin
        if (debugRegisterSelect_q == `DPRS_SEL_PART)
            readValue = PART_ID;
        else if (debugRegisterSelect_q == `DPRS_SEL_REVISION)
            readValue = REV_ID;
        else if (debugRegisterSelect_q == `DPRS_SEL_PROG_CTRL)
            readValue = progCtrl_q;
        else if (debugRegisterSelect_q == `DPRS_SEL_PROG_DATA)
            readValue = progData_q;
        else
            readValue = `DPRS_BYTE_ZERO;
    end

    // ----------------------------------------
    // frame engine
    // ----------------------------------------
    reg [1:0] state_q;
    reg [2:0] bitCnt_q;
    reg [1:0] ins_q;
    reg [7:0] shift_q;
    reg driveOn_q;
    reg unlockArmed_q;
    reg [7:0] wrByte;

    always @*
    begin
        wrByte = {datSync_q, shift_q[7:1]};
    end

    assign debugDataPinOut = shift_q[0];
    assign debugDataPinOe = driveOn_q;

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            bitCnt_q <= 3'h0;
            ins_q <= 2'h0;
            shift_q <= `DPRS_BYTE_ZERO;
            driveOn_q <= 1'b0;
            debugRegisterSelect_q <= `DPRS_SEL_RESET;
            progCtrl_q <= `DPRS_BYTE_ZERO;
            progData_q <= `DPRS_BYTE_ZERO;
            unlockArmed_q <= 1'b0;
            progEnabled_q <= 1'b0;
            progDataWrite_q <= 1'b0;
            progCmdMatch_q <= 1'b0;
        end
        else
        begin
            progDataWrite_q <= 1'b0;
            if (progDataLoad)
                progData_q <= progDataIn;
            case (state_q)
            ST_IDLE:
            begin
                // start: host holds data low at a rising edge
                if (linkRise && !datSync_q)
                begin
                    state_q <= ST_INS;
                    bitCnt_q <= 3'h0;
                end
            end
            ST_INS:
            begin
                if (linkRise)
                begin
                    ins_q <= {datSync_q, ins_q[1]};
                    bitCnt_q <= bitCnt_q + 3'h1;
                    if (bitCnt_q == `DPRS_INS_LAST)
                    begin
                        bitCnt_q <= 3'h0;
                        // bit 0 marks a write, bit 1 the select register
                        if (ins_q[1])
                        begin
                            state_q <= ST_DIN;
                        end
                        else
                        begin
                            // device answers on the shared line
                            state_q <= ST_DOUT;
                            driveOn_q <= 1'b1;
                            if (datSync_q)
                                shift_q <= debugRegisterSelect_q;
                            else
                                shift_q <= readValue;
                        end
                    end
                end
            end
            ST_DIN:
            begin
                if (linkRise)
                begin
                    shift_q <= wrByte;
                    bitCnt_q <= bitCnt_q + 3'h1;
                    if (bitCnt_q == `DPRS_DATA_LAST)
                    begin
                        state_q <= ST_IDLE;
                        if (ins_q == `DPRS_INS_ADDR_WRITE)
                            debugRegisterSelect_q <= wrByte;
                        else if (debugRegisterSelect_q ==
                                 `DPRS_SEL_PROG_CTRL)
                        begin
                            progCtrl_q <= wrByte;
                            // any other byte breaks the sequence
                            unlockArmed_q <= (wrByte ==
                                              `DPRS_UNLOCK_FIRST);
                            if (unlockArmed_q &&
                                wrByte == `DPRS_UNLOCK_SECOND)
                                progEnabled_q <= 1'b1;
                        end
                        else if (debugRegisterSelect_q ==
                                 `DPRS_SEL_PROG_DATA)
                        begin
                            progData_q <= wrByte;
                            progDataWrite_q <= progEnabled_q;
                            progCmdMatch_q <=
                                (wrByte == `DPRS_CMD_BLOCK_READ) ||
                                (wrByte == `DPRS_CMD_BLOCK_WRITE) ||
                                (wrByte == `DPRS_CMD_PAGE_ERASE) ||
                                (wrByte == `DPRS_CMD_DEVICE_ERASE);
                        end
                        // identifier and unlisted selects drop it
                    end
                end
            end
            ST_DOUT:
            begin
                if (linkRise)
                begin
                    bitCnt_q <= bitCnt_q + 3'h1;
                    if (bitCnt_q == `DPRS_DATA_LAST)
                    begin
                        state_q <= ST_IDLE;
                        driveOn_q <= 1'b0;
                    end
                end
                // first fall skipped: bit 0 stands until the first data edge
                else if (linkFall && bitCnt_q != 3'h0)
                    shift_q <= {1'b0, shift_q[7:1]};
            end
            default:
                state_q <= ST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// file: dv/dprs_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dprs_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // watched ports
    input wire logic progDataLoad,
    input wire logic [7:0] progDataIn,
    input wire logic progEnabled_q,
    input wire logic progDataWrite_q,
    input wire logic progCmdMatch_q,
    input wire logic [7:0] progData_q,
    input wire logic [7:0] debugRegisterSelect_q
);
    // ------
    // checks
    // ------
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence wrPulse;
        progDataWrite_q ##1 !progDataWrite_q;
    endsequence
    sel_reset_a: assert property ($fell(reset) |->
        debugRegisterSelect_q == 8'h00) else $error("select not zero");
    en_reset_a: assert property ($fell(reset) |->
        !progEnabled_q) else $error("enable not clear");
    en_sticky_a: assert property (progEnabled_q |=>
        progEnabled_q) else $error("enable dropped");
    en_rise_a: assert property ($rose(progEnabled_q) |->
        debugRegisterSelect_q == 8'h02) else $error("enable bad select");
    pulse_short_a: assert property ($rose(progDataWrite_q) |->
        wrPulse) else $error("write pulse long");
    pulse_gate_a: assert property (progDataWrite_q |->
        progEnabled_q && debugRegisterSelect_q == 8'hB4) else $error("bad pulse");
    cmd_flag_a: assert property (progDataWrite_q |-> progCmdMatch_q ==
        (progData_q inside {8'h06, 8'h07, 8'h08, 8'h03})) else $error("cmd flag");
    load_data_a: assert property (progDataLoad |=>
        progData_q == $past(progDataIn)) else $error("load lost");
endmodule
bind dprs_debug_port dprs_chk dprs_chk_inst (.*);
`default_nettype wire

// file: dv/dprs_host.sv
`timescale 1ns/1ps
`default_nettype none
module dprs_host (
    // clock
    input wire logic core_clk,
    // link
    input wire logic devOut,
    input wire logic devOe,
    output logic linkClk,
    output logic lineLevel
);
    // ------
    // host
    // ------
    logic hostD = 1'b1;
    logic hostOe = 1'b1;
    logic floatBit = 1'b0;
    initial linkClk = 1'b0;
    // released line wanders so a missing drive shows
    always @(posedge core_clk) floatBit <= ~floatBit;
    assign lineLevel = hostOe ? hostD : devOe ? devOut : floatBit;
    task automatic slot(input logic d, drv, keep, output logic s);
        @(posedge core_clk);
        #1 hostOe = drv;
        hostD = d;
        repeat (8) @(posedge core_clk);
        #1 linkClk = 1'b1;
        s = lineLevel;
        // hold the line past the device's sampling flop before letting go
        @(posedge core_clk);
        #1 hostOe = keep;
        repeat (7) @(posedge core_clk);
        #1 linkClk = 1'b0;
    endtask
    task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
        output logic [7:0] rd);
        logic s;
        integer i;
        slot(1'b0, 1'b1, 1'b1, s);
        slot(ins[0], 1'b1, 1'b1, s);
        slot(ins[1], 1'b1, ins[0], s);
        for (i = 0; i < 8; i++)
        begin
            slot(wd[i], ins[0], ins[0], s);
            rd[i] = s;
        end
        hostOe = 1'b1;
        hostD = 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// file: dv/test_debug_port_register_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_debug_port_register_select;
    // ------
    // bench
    // ------
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic progDataLoad = 1'b0;
    logic [7:0] progDataIn = 8'h00;
    wire linkClk, lineLevel, devOut, devOe, enQ, wrQ, matchQ;
    wire [7:0] dataQ, selQ;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    int pulses = 0;
    logic [7:0] codes [5] = '{8'h06, 8'h07, 8'h08, 8'h03, 8'h55};
    dprs_debug_port #(.PART_ID(8'h3C), .REV_ID(8'h21)) dprs_debug_port_inst (
        .core_clk(core_clk), .reset(reset), .debugClockPin(linkClk),
        .debugDataPinIn(lineLevel), .debugDataPinOut(devOut),
        .debugDataPinOe(devOe), .progDataLoad(progDataLoad),
        .progDataIn(progDataIn), .progEnabled_q(enQ), .progDataWrite_q(wrQ),
        .progCmdMatch_q(matchQ), .progData_q(dataQ),
        .debugRegisterSelect_q(selQ));
    dprs_host dprs_host_inst (.core_clk(core_clk), .devOut(devOut),
        .devOe(devOe), .linkClk(linkClk), .lineLevel(lineLevel));
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (wrQ === 1'b1)
            pulses++;
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [7:0] g, e);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic op(input logic [1:0] ins, input logic [7:0] d);
        logic [7:0] r;
        dprs_host_inst.frame(ins, d, r);
        if (!ins[0])
            chk(r, d);
    endtask
    task automatic t_ident();
        op(0, 8'h3C);
        op(1, 8'h55);
        op(0, 8'h3C);
        op(3, 8'h01);
        op(0, 8'h21);
        op(1, 8'h55);
        op(0, 8'h21);
        op(3, 8'h7F);
        op(2, 8'h7F);
        op(1, 8'hAA);
        op(0, 8'h00);
    endtask
    task automatic t_unlock();
        op(3, 8'h02);
        op(1, 8'h01);
        op(1, 8'h02);
        op(1, 8'h05);
        op(1, 8'h01);
        chk({7'h00, enQ}, 8'h00);
        op(1, 8'h02);
        op(1, 8'h01);
        chk({7'h00, enQ}, 8'h01);
        op(0, 8'h01);
    endtask
    task automatic t_prog();
        int i;
        int p;
        p = pulses;
        op(3, 8'hB4);
        for (i = 0; i < 5; i++)
        begin
            op(1, codes[i]);
            chk(dataQ, codes[i]);
            chk({7'h00, matchQ}, {7'h00, i < 4});
            chk(8'(pulses - p), 8'(i + 1));
        end
        op(0, 8'h55);
        @(posedge core_clk);
        #1 progDataLoad = 1'b1;
        progDataIn = 8'hA5;
        @(posedge core_clk);
        #1 progDataLoad = 1'b0;
        op(0, 8'hA5);
    endtask
    task automatic t_reset();
        int p;
        @(posedge core_clk);
        #1 reset = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 reset = 1'b0;
        chk(selQ, 8'h00);
        chk({7'h00, enQ}, 8'h00);
        op(0, 8'h3C);
        p = pulses;
        op(3, 8'hB4);
        op(1, 8'h07);
        chk(dataQ, 8'h07);
        chk({7'h00, matchQ}, 8'h01);
        chk(8'(pulses - p), 8'h00);
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk);
        #1 reset = 1'b0;
        repeat (3) @(posedge core_clk);
        t_ident();
        t_unlock();
        t_prog();
        t_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
